// *** rtl/acs_sequencer.v ***
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "acs_defines.vh"

module acs_sequencer #(
	parameter [7:0] SENSOR_GAIN_CAL   = 8'h80,
	parameter [7:0] SENSOR_OFFSET_CAL = 8'h00
) (
	// clock and reset
	input  wire          clock,
	input  wire          rst,
	// apb slave
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [7:0]    paddr,
	input  wire [31:0]   pwdata,
	output wire [31:0]   prdata,
	output wire          pready,
	output wire          pslverr,
	// analog side
	input  wire          trigger_in,
	input  wire [9:0]    adc_result_in,
	output wire [4:0]    channel_select_field,
	output wire [1:0]    reference_select,
	output wire          sample_hold,
	output wire          converting,
	// interrupt
	output wire          irq
);

	// ***************************************************************
	// states
	// ***************************************************************
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_WAIT = 3'b010;
	localparam [2:0] ST_CONV = 3'b100;

	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg  [5:0]  half_reg;
	reg  [5:0]  half_next;
	reg         enable_reg;
	reg         enable_next;
	reg         start_reg;
	reg         start_next;
	reg         first_reg;
	reg         first_next;
	reg         auto_reg;
	reg  [2:0]  ps_reg;
	reg         trig_src_reg;
	reg  [4:0]  chan_reg;
	reg  [1:0]  ref_reg;
	reg  [9:0]  result_reg;
	reg  [1:0]  irq_stat_reg;
	reg  [1:0]  irq_en_reg;
	reg         sh_reg;
	reg         sh_next;
	reg         done;
	reg         restart;
	reg  [31:0] prdata_reg;
	reg  [31:0] rd_val;
	reg         trig_meta_reg;
	reg         trig_sync_reg;
	reg         trig_prev_reg;
	reg         trig_edge_reg;
	wire        rise_tick;
	wire        fall_tick;
	wire        wr;
	wire        sw_start;
	wire [5:0]  sh_target;
	wire [5:0]  total;
	wire [1:0]  irq_set;
	wire [1:0]  irq_clr;

	// ***************************************************************
	// address decode
	// ***************************************************************
	function is_mapped;
		input [7:0] a;
		begin
			case (a)
				`ACS_OFF_CTRL, `ACS_OFF_CHAN, `ACS_OFF_RES_LO, `ACS_OFF_RES_HI,
				`ACS_OFF_IRQ_STAT, `ACS_OFF_IRQ_CLR, `ACS_OFF_IRQ_EN,
				`ACS_OFF_TRIG, `ACS_OFF_CAL: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	function wr_hit;
		input [7:0] a;
		input [7:0] off;
		input       w;
		begin
			wr_hit = w && (a == off);
		end
	endfunction

	assign wr       = psel && penable && pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !is_mapped(paddr);
	assign prdata   = prdata_reg;
	assign sw_start = wr_hit(paddr, `ACS_OFF_CTRL, wr) && pwdata[`ACS_CTRL_START];

	// ***************************************************************
	// converter clock
	// ***************************************************************
	acs_prescaler #(
		.CW (7)
	) u_prescaler (
		.clock           (clock),
		.rst             (rst),
		.enable          (enable_reg),
		.restart         (restart),
		.prescale_select (ps_reg),
		.rise_tick       (rise_tick),
		.fall_tick       (fall_tick)
	);

	// ***************************************************************
	// trigger synchroniser and edge detect
	// ***************************************************************
	always @(posedge clock) begin
		if (rst) begin
			trig_meta_reg <= 1'b0;
			trig_sync_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
			trig_edge_reg <= 1'b0;
		end else begin
			trig_meta_reg <= trigger_in;
			trig_sync_reg <= trig_meta_reg;
			trig_prev_reg <= trig_sync_reg;
			trig_edge_reg <= trig_sync_reg && !trig_prev_reg;
		end
	end

	// ***************************************************************
	// conversion sequencer
	// ***************************************************************
	assign total     = first_reg ? `ACS_FIRST_HALVES : `ACS_NORM_HALVES;
	assign sh_target = first_reg ? `ACS_SH_FIRST :
	                   (auto_reg && trig_src_reg) ? `ACS_SH_TRIG : `ACS_SH_NORM;

	always @* begin
		state_next  = state_reg;
		half_next   = half_reg;
		start_next  = start_reg || sw_start;
		first_next  = first_reg;
		enable_next = enable_reg;
		sh_next     = 1'b0;
		done        = 1'b0;
		restart     = 1'b0;
		if (wr_hit(paddr, `ACS_OFF_CTRL, wr))
			enable_next = pwdata[`ACS_CTRL_EN];
		if (!enable_reg && enable_next)
			first_next = 1'b1;
		case (state_reg)
			ST_IDLE: begin
				if (auto_reg && trig_src_reg && trig_edge_reg) begin
					restart    = 1'b1;
					start_next = 1'b1;
					state_next = ST_WAIT;
				end else if (start_reg) begin
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (rise_tick) begin
					state_next = ST_CONV;
					half_next  = 6'd0;
				end
			end
			ST_CONV: begin
				if (rise_tick || fall_tick) begin
					half_next = half_reg + 6'd1;
					if (half_next == sh_target)
						sh_next = 1'b1;
					if (half_next == total) begin
						done       = 1'b1;
						half_next  = 6'd0;
						first_next = 1'b0;
						if (auto_reg && !trig_src_reg) begin
							state_next = ST_CONV;
						end else begin
							state_next = ST_IDLE;
							start_next = sw_start;
						end
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (!enable_next) begin
			state_next = ST_IDLE;
			half_next  = 6'd0;
			start_next = 1'b0;
			done       = 1'b0;
			sh_next    = 1'b0;
			restart    = 1'b0;
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			state_reg  <= ST_IDLE;
			half_reg   <= 6'd0;
			enable_reg <= 1'b0;
			start_reg  <= 1'b0;
			first_reg  <= 1'b0;
			sh_reg     <= 1'b0;
			result_reg <= 10'h000;
		end else begin
			state_reg  <= state_next;
			half_reg   <= half_next;
			enable_reg <= enable_next;
			start_reg  <= start_next;
			first_reg  <= first_next;
			sh_reg     <= sh_next;
			if (done)
				result_reg <= adc_result_in;
		end
	end

	// ***************************************************************
	// software registers
	// ***************************************************************
	assign irq_set = {sh_next, done};
	assign irq_clr = wr_hit(paddr, `ACS_OFF_IRQ_CLR, wr) ? pwdata[1:0] : 2'h0;

	always @(posedge clock) begin
		if (rst) begin
			auto_reg     <= 1'b0;
			ps_reg       <= `ACS_RST_PS;
			trig_src_reg <= 1'b0;
			chan_reg     <= `ACS_RST_CHAN;
			ref_reg      <= `ACS_RST_REF;
			irq_en_reg   <= 2'h0;
			irq_stat_reg <= 2'h0;
		end else begin
			if (wr_hit(paddr, `ACS_OFF_CTRL, wr)) begin
				auto_reg <= pwdata[`ACS_CTRL_AUTO];
				ps_reg   <= pwdata[`ACS_CTRL_PS_HI:`ACS_CTRL_PS_LO];
			end
			if (wr_hit(paddr, `ACS_OFF_CHAN, wr)) begin
				chan_reg <= pwdata[`ACS_CHAN_HI:`ACS_CHAN_LO];
				ref_reg  <= pwdata[`ACS_REF_HI:`ACS_REF_LO];
			end
			if (wr_hit(paddr, `ACS_OFF_TRIG, wr))
				trig_src_reg <= pwdata[`ACS_TRIG_EXT];
			if (wr_hit(paddr, `ACS_OFF_IRQ_EN, wr))
				irq_en_reg <= pwdata[1:0];
			// set wins over a clear in the same cycle
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
		end
	end

	// ***************************************************************
	// read path, latched in the setup cycle
	// ***************************************************************
	always @* begin
		rd_val = 32'h0000_0000;
		case (paddr)
			`ACS_OFF_CTRL: begin
				rd_val[`ACS_CTRL_EN]    = enable_reg;
				rd_val[`ACS_CTRL_START] = start_reg;
				rd_val[`ACS_CTRL_AUTO]  = auto_reg;
				rd_val[`ACS_CTRL_FLAG]  = irq_stat_reg[`ACS_IRQ_DONE];
				rd_val[`ACS_CTRL_PS_HI:`ACS_CTRL_PS_LO] = ps_reg;
			end
			`ACS_OFF_CHAN: begin
				rd_val[`ACS_CHAN_HI:`ACS_CHAN_LO] = chan_reg;
				rd_val[`ACS_REF_HI:`ACS_REF_LO]   = ref_reg;
			end
			`ACS_OFF_RES_LO:   rd_val[7:0] = result_reg[7:0];
			`ACS_OFF_RES_HI:   rd_val[1:0] = result_reg[9:8];
			`ACS_OFF_IRQ_STAT: rd_val[1:0] = irq_stat_reg;
			`ACS_OFF_IRQ_EN:   rd_val[1:0] = irq_en_reg;
			`ACS_OFF_TRIG:     rd_val[0]   = trig_src_reg;
			`ACS_OFF_CAL:      rd_val[15:0] = {SENSOR_OFFSET_CAL, SENSOR_GAIN_CAL};
			default:           rd_val = 32'h0000_0000;
		endcase
	end

	always @(posedge clock) begin
		if (rst)
			prdata_reg <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata_reg <= rd_val;
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign channel_select_field = chan_reg;
	assign reference_select     = ref_reg;
	assign sample_hold          = sh_reg;
	assign converting           = state_reg[2];
	assign irq                  = |(irq_stat_reg & irq_en_reg);

endmodule

// *** inc/acs_defines.vh ***
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define ACS_OFF_CTRL     8'h00
`define ACS_OFF_CHAN     8'h04
`define ACS_OFF_RES_LO   8'h08
`define ACS_OFF_RES_HI   8'h0C
`define ACS_OFF_IRQ_STAT 8'h10
`define ACS_OFF_IRQ_CLR  8'h14
`define ACS_OFF_IRQ_EN   8'h18
`define ACS_OFF_TRIG     8'h1C
`define ACS_OFF_CAL      8'h20

// ***************************************************************
// control_status fields
// ***************************************************************
`define ACS_CTRL_EN      7
`define ACS_CTRL_START   6
`define ACS_CTRL_AUTO    5
`define ACS_CTRL_FLAG    4
`define ACS_CTRL_PS_HI   2
`define ACS_CTRL_PS_LO   0

// ***************************************************************
// channel select fields
// ***************************************************************
`define ACS_CHAN_HI      4
`define ACS_CHAN_LO      0
`define ACS_REF_HI       7
`define ACS_REF_LO       6

// ***************************************************************
// interrupt bits, trigger source
// ***************************************************************
`define ACS_IRQ_DONE     0
`define ACS_IRQ_SAMPLE   1
`define ACS_TRIG_EXT     0

// ***************************************************************
// reset values
// ***************************************************************
`define ACS_RST_PS       3'h0
`define ACS_RST_CHAN     5'h00
`define ACS_RST_REF      2'h0

// ***************************************************************
// timing, in half converter clock cycles
// ***************************************************************
`define ACS_NORM_HALVES  6'd26
`define ACS_FIRST_HALVES 6'd50
`define ACS_SH_NORM      6'd3
`define ACS_SH_FIRST     6'd29
`define ACS_SH_TRIG      6'd2

`endif

// *** rtl/acs_prescaler.v ***
`timescale 1ns/10ps
`include "acs_defines.vh"

module acs_prescaler #(
	parameter CW = 7
) (
	// clock and reset
	input  wire          clock,
	input  wire          rst,
	// control
	input  wire          enable,
	input  wire          restart,
	input  wire [2:0]    prescale_select,
	// converter clock edges
	output reg           rise_tick,
	output reg           fall_tick
);

	reg  [CW-1:0] cnt_reg;
	wire [CW:0]   div_val;
	wire          wrap;

	// division factor: 2 for selects 0 and 1, else 2^select
	function [CW:0] acs_div;
		input [2:0] sel;
		begin
			if (sel == 3'h0)
				acs_div = {{(CW-1){1'b0}}, 2'b10};
			else
				acs_div = {{CW{1'b0}}, 1'b1} << sel;
		end
	endfunction

	assign div_val = acs_div(prescale_select);
	// greater-or-equal catches a divisor shrunk while counting
	assign wrap    = ({1'b0, cnt_reg} >= div_val - 1'b1);

	always @(posedge clock) begin
		if (rst || !enable || restart) begin
			cnt_reg   <= {CW{1'b0}};
			rise_tick <= 1'b0;
			fall_tick <= 1'b0;
		end else begin
			cnt_reg   <= wrap ? {CW{1'b0}} : cnt_reg + 1'b1;
			rise_tick <= wrap;
			fall_tick <= ({1'b0, cnt_reg} == (div_val >> 1) - 1'b1);
		end
	end

endmodule

// *** verif/acs_seq_sva.sv ***
`timescale 1ns/10ps
module acs_seq_sva (
	// clock and reset
	input wire        clock,
	input wire        rst,
	// apb
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// converter side
	input wire [4:0]  channel_select_field,
	input wire [1:0]  reference_select,
	input wire        sample_hold,
	input wire        converting,
	input wire        irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	wire acc = psel && penable && pready;

	chk_sh_pulse: assert property (sample_hold |=> !sample_hold)
		else $error("sample hold longer than one cycle");
	chk_sh_inside: assert property (sample_hold |-> converting)
		else $error("sample hold outside conversion");
	chk_sh_late: assert property ($rose(converting) |-> !sample_hold [*2])
		else $error("sample hold too early");
	chk_conv_min: assert property ($rose(converting) |-> converting [*8])
		else $error("conversion too short");
	chk_chan_write: assert property (acc && pwrite && paddr == 8'h04 |=>
		channel_select_field == $past(pwdata[4:0]) && reference_select == $past(pwdata[7:6]))
		else $error("channel select not updated");
	chk_off_stops: assert property (acc && pwrite && paddr == 8'h00 && !pwdata[7] |=>
		##[0:2] !converting)
		else $error("conversion not stopped by disable");
	chk_reset_quiet: assert property (disable iff (1'b0) rst |=>
		!converting && !irq && !sample_hold && prdata == 32'h0000_0000)
		else $error("outputs not quiet after reset");
	chk_unmapped_err: assert property (acc && paddr > 8'h20 |-> pslverr)
		else $error("unmapped access without error");
	chk_mapped_ok: assert property (acc && paddr <= 8'h20 && paddr[1:0] == 2'h0 |->
		!pslverr)
		else $error("error on mapped access");
endmodule

// *** verif/acs_analog_model.sv ***
`timescale 1ns/10ps
module acs_analog_model #(
	parameter [4:0] TEMP_CH = 5'h08, // arbitrary sensor channel
	parameter [1:0] REF_INT = 2'h3   // arbitrary internal reference code
) (
	// clock
	input wire        clock,
	// from sequencer
	input wire [4:0]  channel_select_field,
	input wire [1:0]  reference_select,
	input wire        sample_hold,
	input wire        converting,
	// result
	output wire [9:0] adc_result_in
);
	reg [9:0] held_reg = 10'h000;
	reg [9:0] junk_reg = 10'h155;
	reg       conv_reg = 1'b0;
	always @(posedge clock) begin
		junk_reg <= ~junk_reg;
		conv_reg <= converting;
		if (sample_hold) begin
			if (channel_select_field == TEMP_CH && reference_select == REF_INT)
				held_reg <= 10'h144;
			else
				held_reg <= {channel_select_field, reference_select, 3'h5};
		end
	end
	// result only meaningful around a conversion
	assign adc_result_in = (converting | conv_reg) ? held_reg : junk_reg;
endmodule

// *** verif/adc_conversion_sequencer_test.sv ***
`timescale 1ns/10ps
`include "acs_defines.vh"
module adc_conversion_sequencer_test;
	reg          clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, trigger_in = 0;
	reg  [7:0]   paddr = 8'h00;
	reg  [31:0]  pwdata = 32'h0000_0000, seed = 32'h0000_8938;
	wire [31:0]  prdata;
	wire         pready, pslverr, sample_hold, converting, irq;
	wire [9:0]   adc_result_in;
	wire [4:0]   chan;
	wire [1:0]   rsel;
	logic [32:0] exp_q[$];
	string       nm_q[$];
	int          bad_count = 0, compares = 0, cyc = 0, n, k, tc;
	logic [15:0] cal;
	logic [9:0]  res;
	logic [4:0]  ch;
	logic [1:0]  rf;
	logic [9:0]  rv;

	acs_sequencer dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trigger_in(trigger_in), .adc_result_in(adc_result_in),
		.channel_select_field(chan), .reference_select(rsel), .sample_hold(sample_hold),
		.converting(converting), .irq(irq));
	acs_analog_model model (.clock(clock), .channel_select_field(chan),
		.reference_select(rsel), .sample_hold(sample_hold), .converting(converting),
		.adc_result_in(adc_result_in));

	initial begin
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			final_report();
		end
	end
	// ***************************************************************
	// helpers
	// ***************************************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [32:0] near(input int got, input int e);
		return (got >= e - 2 && got <= e + 2) ? e : got;
	endfunction
	task check(input string nm, input logic [32:0] got, input logic [32:0] e);
		compares++;
		if (got !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, got);
		end
	endtask
	task final_report;
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task apb(input [7:0] a, input bit w, input [31:0] d);
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task rd(input [7:0] a, input [32:0] e, input string nm);
		exp_q.push_back(e);
		nm_q.push_back(nm);
		apb(a, 0, 32'h0000_0000);
	endtask
	always @(posedge clock)
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
			check(nm_q.pop_front(), {pslverr, prdata}, exp_q.pop_front());
	task conv(input [2:0] ps, input bit first);
		int d, sh, tot, s, t;
		d = (ps < 2) ? 2 : (1 << ps);
		s = (first ? 29 : 3) * d / 2;
		t = (first ? 50 : 26) * d / 2;
		apb(`ACS_OFF_CTRL, 1, 32'h0000_00c0 | ps);
		n = 0;
		while (converting !== 1'b1 && n < 300) begin
			@(negedge clock);
			n++;
		end
		check("start_wait", n <= d + 3, 1);
		sh = 0;
		tot = 0;
		while (converting === 1'b1 && tot < 4000) begin
			@(negedge clock);
			tot++;
			if (sample_hold === 1'b1)
				sh = tot;
		end
		check("sh_time", near(sh, s), s);
		check("conv_time", near(tot, t), t);
	endtask
	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		repeat (8) @(posedge clock);
		rst <= 0;
		rd(`ACS_OFF_CAL, 33'h0_0000_0080, "cal");
		cal = prdata[15:0];
		rd(8'h30, 33'h1_0000_0000, "unmapped");
		rd(`ACS_OFF_CTRL, 33'h0_0000_0000, "ctrl_reset");
		apb(`ACS_OFF_CHAN, 1, 32'h0000_00c8);
		apb(`ACS_OFF_IRQ_EN, 1, 32'h0000_0001);
		conv(3, 1);
		rd(`ACS_OFF_RES_LO, 33'h0_0000_0044, "res_low");
		res[7:0] = prdata[7:0];
		rd(`ACS_OFF_RES_HI, 33'h0_0000_0001, "res_high");
		res[9:8] = prdata[1:0];
		// software temperature: (324 - 298) * 128 / 128 + 25
		tc = ((int'(res) - (273 + 25 - int'($signed(cal[15:8])))) * 128) / int'(cal[7:0]) + 25;
		check("temp_c", tc, 51);
		rd(`ACS_OFF_CTRL, 33'h0_0000_0093, "ctrl_done");
		check("irq_set", irq, 1);
		apb(`ACS_OFF_IRQ_CLR, 1, 32'h0000_0003);
		repeat (2) @(negedge clock);
		check("irq_clear", irq, 0);
		rd(`ACS_OFF_IRQ_STAT, 33'h0_0000_0000, "stat_clear");
		apb(`ACS_OFF_IRQ_EN, 1, 32'h0000_0000);
		seed = xs(seed);
		ch = seed[4:0];
		rf = seed[6] ? 2'h1 : 2'h2;
		rv = {ch, rf, 3'h5};
		apb(`ACS_OFF_CHAN, 1, {24'h00_0000, rf, 1'b0, ch});
		rd(`ACS_OFF_CHAN, {25'h0, rf, 1'b0, ch}, "chan");
		for (int p = 0; p < 8; p++)
			conv(p, 0);
		rd(`ACS_OFF_RES_LO, {25'h0, rv[7:0]}, "res_low2");
		rd(`ACS_OFF_RES_HI, {31'h0, rv[9:8]}, "res_high2");
		check("irq_masked", irq, 0);
		rd(`ACS_OFF_IRQ_STAT, 33'h0_0000_0003, "stat_masked");
		apb(`ACS_OFF_TRIG, 1, 32'h0000_0000);
		apb(`ACS_OFF_CTRL, 1, 32'h0000_00e3);
		n = 0;
		k = 0;
		while (k < 3 && n < 2000) begin
			@(negedge clock);
			n++;
			if (sample_hold === 1'b1)
				k++;
		end
		check("free_runs", k, 3);
		rd(`ACS_OFF_CTRL, 33'h0_0000_00f3, "ctrl_free");
		apb(`ACS_OFF_CTRL, 1, 32'h0000_0000);
		repeat (3) @(negedge clock);
		check("disabled", converting, 0);
		rd(`ACS_OFF_CTRL, 33'h0_0000_0010, "ctrl_off");
		apb(`ACS_OFF_TRIG, 1, 32'h0000_0001);
		apb(`ACS_OFF_CTRL, 1, 32'h0000_00a3);
		// first trigger after enable: sync 3, start 8, sample 116, seen one negedge late
		// second trigger: sync 3, two converter cycles 16, seen one negedge late
		for (int r = 0; r < 2; r++) begin
			k = r ? 20 : 128;
			repeat (5) @(posedge clock);
			trigger_in <= 1;
			n = 0;
			while (sample_hold !== 1'b1 && n < 200) begin
				@(negedge clock);
				n++;
			end
			check("trig_sh", near(n, k), k);
			while (converting === 1'b1 && n < 400) begin
				@(negedge clock);
				n++;
			end
			@(posedge clock);
			trigger_in <= 0;
		end
		final_report();
	end
endmodule
bind acs_sequencer acs_seq_sva chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .channel_select_field(channel_select_field),
	.reference_select(reference_select), .sample_hold(sample_hold),
	.converting(converting), .irq(irq));
